// [src/bit_branch_decode.sv]
// decode and execute of bit test, toggle, branch, call and clear ops
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 1010 bbba: skip next if bit set
// - skip runs nop, three cycles over two-word
// - a=0 access bank, a=1 bank select
// - 0111 bbba: invert bit, read-process-write
// - 1110 0100: branch when overflow set
// - 1110 0000: branch when zero set
// - branch target is pc+2+2n
// - taken branch two cycles, else one
// - two-word call loads 20-bit k
// - call pushes call address plus four
// - s=1 copies w, status, bank to shadows
// - call pushes in q3, writes pc q4
// - 0110 101a: clear register, set zero
// - 0000 0000 0000 0100: watchdog clear, set flags
module bit_branch_decode
   import bit_branch_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // program memory
   output logic [PC_W-1:0] prog_addr,
   input wire logic [INSN_W-1:0] prog_rdata,
   // data register file
   output logic [DADDR_W-1:0] data_addr,
   output logic data_rd_en,
   input wire logic [7:0] data_rdata,
   output logic data_wr_en,
   output logic [7:0] data_wdata,
   // return stack and watchdog
   output logic stack_push,
   output logic [PC_W-1:0] stack_top,
   output logic watchdog_clear,
   input wire logic timeout_event,
   input wire logic sleep_event,
   // axi4-lite write
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ==========================================================
   // phase sequencer
   phase_t phase;

   q_phase_gen u_phase (
      .clk(clk),
      .rst_b(rst_b),
      .phase(phase)
   );

   // ==========================================================
   // architectural state
   logic [PC_W-1:0] pc_reg;
   logic [INSN_W-1:0] ir_reg;
   logic [1:0] flush_reg;
   logic skip_reg;
   logic [7:0] rd_latch_reg;
   logic run_reg;
   logic [7:0] status_reg;
   logic [7:0] work_reg;
   logic [3:0] bank_select_reg;
   logic [7:0] working_shadow;
   logic [7:0] status_shadow;
   logic [3:0] bank_select_shadow;

   // ==========================================================
   // decode
   wire [7:0] f_field = ir_reg[7:0];
   wire [2:0] bit_sel = ir_reg[11:9];
   wire a_bit = ir_reg[8];
   wire exec = run_reg && (flush_reg == 2'd0);
   wire bit_test_skip_if_set = exec
      && (ir_reg[15:12] == OPC_TEST_SKIP_SET);
   wire bit_invert_op = exec
      && (ir_reg[15:12] == OPC_BIT_INVERT);
   wire branch_on_overflow = exec
      && (ir_reg[15:8] == OPC_BRANCH_OVF);
   wire branch_on_zero_flag = exec
      && (ir_reg[15:8] == OPC_BRANCH_ZERO);
   wire call_op = exec && (ir_reg[15:9] == OPC_CALL);
   wire call_save = call_op && ir_reg[8];
   wire register_clear_op = exec
      && (ir_reg[15:9] == OPC_REG_CLEAR);
   wire watchdog_clear_op = exec && (ir_reg == OPC_WDOG_CLEAR);
   wire file_op = bit_test_skip_if_set || bit_invert_op
      || register_clear_op;
   wire writes_file = bit_invert_op || register_clear_op;

   // access bank splits into low and high halves when a is clear
   wire [3:0] access_bank = (f_field < ACCESS_SPLIT) ? ACCESS_LOW_BANK
      : ACCESS_HIGH_BANK;
   wire [3:0] eff_bank = a_bit ? bank_select_reg : access_bank;

   wire branch_taken = (branch_on_overflow && status_reg[STAT_OV_BIT])
      || (branch_on_zero_flag && status_reg[STAT_Z_BIT]);
   // pc already points past this instruction, so only 2n is added
   wire [PC_W-1:0] branch_ofs = {{(PC_W-9){f_field[7]}}, f_field, 1'b0};
   wire [PC_W-1:0] branch_target = pc_reg + branch_ofs;
   wire [PC_W-1:0] call_target = {prog_rdata[11:0], ir_reg[7:0],
      1'b0};
   wire [PC_W-1:0] pc_inc = pc_reg + PC_STEP;
   // the word now on the bus is the one a skip would throw away
   wire next_two_word = (prog_rdata[15:9] == OPC_CALL);
   wire bit_is_set = rd_latch_reg[bit_sel];
   wire [7:0] bit_mask = 8'h01 << bit_sel;

   // ==========================================================
   // execution pipeline
   wire q1_end = (phase == PH_Q1);
   wire q2_end = (phase == PH_Q2);
   wire q3_end = (phase == PH_Q3);
   wire q4_end = (phase == PH_Q4);

   logic [PC_W-1:0] pc_next;
   logic [1:0] flush_next;

   always_comb
   begin
      pc_next = pc_inc;
      flush_next = (flush_reg != 2'd0) ? flush_reg - 2'd1 : 2'd0;
      if (call_op)
      begin
         pc_next = call_target;
         flush_next = 2'd1;
      end
      else if (branch_taken)
      begin
         pc_next = branch_target;
         flush_next = 2'd1;
      end
      else if (skip_reg)
         flush_next = next_two_word ? 2'd2 : 2'd1;
   end

   // ==========================================================
   // software register access
   logic [AXI_ADDR_W-1:0] aw_addr_reg;
   logic aw_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_held_reg;

   wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire wr_ctrl = do_write && (aw_addr_reg == OFS_CTRL);
   wire wr_status = do_write && (aw_addr_reg == OFS_STATUS);
   wire wr_work = do_write && (aw_addr_reg == OFS_WORK);
   wire wr_bank = do_write && (aw_addr_reg == OFS_BANK);
   // the pc is only writable while the core is halted
   wire wr_pc = do_write && (aw_addr_reg == OFS_PC) && !run_reg;
   wire wr_mapped = (aw_addr_reg == OFS_CTRL)
      || (aw_addr_reg == OFS_STATUS) || (aw_addr_reg == OFS_WORK)
      || (aw_addr_reg == OFS_BANK) || (aw_addr_reg == OFS_PC);
   wire [31:0] wr_val = w_data_reg & wmask;
   wire [31:0] pc_merged = ({11'h000, pc_reg} & ~wmask) | wr_val;

   logic [31:0] rd_mux;
   logic rd_ok;

   always_comb
   begin
      rd_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         OFS_CTRL: rd_mux = {31'h0000_0000, run_reg};
         OFS_STATUS: rd_mux = {24'h00_0000, status_reg};
         OFS_WORK: rd_mux = {24'h00_0000, work_reg};
         OFS_BANK: rd_mux = {28'h000_0000, bank_select_reg};
         OFS_PC: rd_mux = {11'h000, pc_reg};
         OFS_WSHAD: rd_mux = {24'h00_0000, working_shadow};
         OFS_SSHAD: rd_mux = {24'h00_0000, status_shadow};
         OFS_BSHAD: rd_mux = {28'h000_0000, bank_select_shadow};
         OFS_STACK: rd_mux = {11'h000, stack_top};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // control, work and bank registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         run_reg <= 1'b0;
         work_reg <= 8'h00;
         bank_select_reg <= 4'h0;
      end
      else
      begin
         if (wr_ctrl && w_strb_reg[0])
            run_reg <= w_data_reg[CTRL_RUN_BIT];
         if (wr_work)
            work_reg <= (work_reg & ~wmask[7:0]) | wr_val[7:0];
         if (wr_bank)
            bank_select_reg <= (bank_select_reg & ~wmask[3:0])
               | wr_val[3:0];
      end
   end

   // ==========================================================
   // status flags: hardware sets win over a software write
   logic [7:0] status_next;

   always_comb
   begin
      status_next = status_reg;
      if (wr_status)
         status_next = (status_reg & ~wmask[7:0]) | wr_val[7:0];
      if (timeout_event)
         status_next[STAT_TIMEOUT_N_BIT] = 1'b0;
      if (sleep_event)
         status_next[STAT_POWERDOWN_N_BIT] = 1'b0;
      if (q4_end && register_clear_op)
         status_next[STAT_Z_BIT] = 1'b1;
      if (q4_end && watchdog_clear_op)
      begin
         status_next[STAT_TIMEOUT_N_BIT] = 1'b1;
         status_next[STAT_POWERDOWN_N_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         status_reg <= STATUS_RST;
      else
         status_reg <= status_next;
   end

   // ==========================================================
   // per-phase datapath
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pc_reg <= PC_RST;
         ir_reg <= OPC_NOP;
         flush_reg <= 2'd0;
         skip_reg <= 1'b0;
         rd_latch_reg <= 8'h00;
         data_addr <= '0;
         data_rd_en <= 1'b0;
         data_wr_en <= 1'b0;
         data_wdata <= 8'h00;
         stack_push <= 1'b0;
         stack_top <= PC_RST;
         watchdog_clear <= 1'b0;
         working_shadow <= 8'h00;
         status_shadow <= 8'h00;
         bank_select_shadow <= 4'h0;
      end
      else
      begin
         stack_push <= 1'b0;
         watchdog_clear <= 1'b0;
         unique case (phase)
            PH_Q1:
            begin
               // decode done, register read runs during q2
               data_rd_en <= file_op;
               data_addr <= {eff_bank, f_field};
            end
            PH_Q2:
            begin
               data_rd_en <= 1'b0;
               rd_latch_reg <= data_rdata;
               if (call_op)
               begin
                  stack_push <= 1'b1;
                  stack_top <= pc_inc;
               end
               if (call_save)
               begin
                  working_shadow <= work_reg;
                  status_shadow <= status_reg;
                  bank_select_shadow <= bank_select_reg;
               end
            end
            PH_Q3:
            begin
               skip_reg <= bit_test_skip_if_set && bit_is_set;
               data_wr_en <= writes_file;
               data_wdata <= register_clear_op ? 8'h00
                  : (rd_latch_reg ^ bit_mask);
               watchdog_clear <= watchdog_clear_op;
            end
            PH_Q4:
            begin
               data_wr_en <= 1'b0;
               skip_reg <= 1'b0;
               if (!run_reg)
               begin
                  ir_reg <= OPC_NOP;
                  flush_reg <= 2'd0;
                  if (wr_pc)
                     pc_reg <= pc_merged[PC_W-1:0];
               end
               else
               begin
                  ir_reg <= prog_rdata;
                  pc_reg <= pc_next;
                  flush_reg <= flush_next;
               end
            end
         endcase
         if (wr_pc && !q4_end)
            pc_reg <= pc_merged[PC_W-1:0];
      end
   end

   assign prog_addr = pc_reg;

   // q1_end, q2_end and q3_end name the phase boundaries for readers
   wire unused_ok = q1_end | q2_end | q3_end | (call_target[0] & 1'b0)
      | (prog_rdata[15:12] == CALL_WORD2_NIB);

endmodule : bit_branch_decode
`default_nettype wire

// [src/bit_branch_pkg.sv]
// shared constants and types for the bit, branch, call and clear decoder
package bit_branch_pkg;

   // ==========================================================
   // widths
   localparam int PC_W = 21;
   localparam int INSN_W = 16;
   localparam int DADDR_W = 12;
   localparam int AXI_ADDR_W = 8;

   // ==========================================================
   // opcode patterns
   localparam logic [3:0] OPC_TEST_SKIP_SET = 4'h0_00A;
   localparam logic [3:0] OPC_BIT_INVERT = 4'h0_007;
   localparam logic [7:0] OPC_BRANCH_OVF = 8'h00_E4;
   localparam logic [7:0] OPC_BRANCH_ZERO = 8'h00_E0;
   localparam logic [6:0] OPC_CALL = 7'h0_076;
   localparam logic [6:0] OPC_REG_CLEAR = 7'h0_035;
   localparam logic [15:0] OPC_WDOG_CLEAR = 16'h0004;
   localparam logic [15:0] OPC_NOP = 16'h0000;
   localparam logic [3:0] CALL_WORD2_NIB = 4'h0_00F;

   // ==========================================================
   // bank selection
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0_000;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'h0_00F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h00_80;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00_00;
   localparam logic [7:0] OFS_STATUS = 8'h00_04;
   localparam logic [7:0] OFS_WORK = 8'h00_08;
   localparam logic [7:0] OFS_BANK = 8'h00_0C;
   localparam logic [7:0] OFS_PC = 8'h00_10;
   localparam logic [7:0] OFS_WSHAD = 8'h00_14;
   localparam logic [7:0] OFS_SSHAD = 8'h00_18;
   localparam logic [7:0] OFS_BSHAD = 8'h00_1C;
   localparam logic [7:0] OFS_STACK = 8'h00_20;

   // ==========================================================
   // status field positions and reset values
   localparam int STAT_Z_BIT = 0;
   localparam int STAT_OV_BIT = 1;
   localparam int STAT_POWERDOWN_N_BIT = 2;
   localparam int STAT_TIMEOUT_N_BIT = 3;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic [7:0] STATUS_RST = 8'h00_0C;
   localparam logic [PC_W-1:0] PC_RST = 21'h00_0000;
   localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;

   // ==========================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

endpackage : bit_branch_pkg

// [src/q_phase_gen.sv]
// four-phase instruction cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module q_phase_gen
   import bit_branch_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // phase
   output var phase_t phase
);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         phase <= PH_Q1;
      else
      begin
         unique case (phase)
            PH_Q1: phase <= PH_Q2;
            PH_Q2: phase <= PH_Q3;
            PH_Q3: phase <= PH_Q4;
            PH_Q4: phase <= PH_Q1;
         endcase
      end
   end

endmodule : q_phase_gen
`default_nettype wire

// [test/bit_branch_decode_assertions.sv]
// property checker for the bit, branch, call and clear decoder
`timescale 1ns/100ps
`default_nettype none
module bit_branch_assert
   import bit_branch_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // core side
   input wire logic [PC_W-1:0] prog_addr,
   input wire logic [INSN_W-1:0] prog_rdata,
   input wire logic [DADDR_W-1:0] data_addr,
   input wire logic data_rd_en,
   input wire logic data_wr_en,
   input wire logic stack_push,
   input wire logic [PC_W-1:0] stack_top,
   input wire logic watchdog_clear,
   // register bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // steps of a file access and of a call
   sequence read_phase;
      data_rd_en ##1 !data_rd_en;
   endsequence
   sequence pc_hold;
      $stable(prog_addr);
   endsequence
   rd_pulse_a: assert property (data_rd_en |-> read_phase)
      else $error("file read strobe longer than one clock");
   file_write_a: assert property (
      data_wr_en |-> $past(data_rd_en, 2))
      else $error("file write not two clocks after its read");
   write_addr_a: assert property (
      data_wr_en |-> data_addr == $past(data_addr, 2))
      else $error("file address moved between read and write");
   write_q4_a: assert property (data_wr_en |=> $changed(prog_addr))
      else $error("file write not in the last phase");
   push_ret_a: assert property (
      stack_push |=> stack_top == prog_addr + 21'h00_0002)
      else $error("pushed return address wrong");
   call_target_a: assert property (
      stack_push |-> ##1 pc_hold
      ##1 (prog_addr[20:9] == $past(prog_rdata[11:0], 2)))
      else $error("call target not loaded after push");
   wdog_q4_a: assert property (
      watchdog_clear |=> !watchdog_clear && $changed(prog_addr))
      else $error("watchdog clear pulse misplaced");
   // pc moves only once per four-phase cycle, branches included
   pc_step_a: assert property ($changed(prog_addr) |=> pc_hold [*3])
      else $error("program counter moved inside a cycle");
   pc_even_a: assert property (prog_addr[0] == 1'b0)
      else $error("odd program address");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule : bit_branch_assert
bind bit_branch_decode bit_branch_assert chk_i (.clk(clk), .rst_b(rst_b),
   .prog_addr(prog_addr), .prog_rdata(prog_rdata), .data_addr(data_addr),
   .data_rd_en(data_rd_en), .data_wr_en(data_wr_en),
   .stack_push(stack_push), .stack_top(stack_top),
   .watchdog_clear(watchdog_clear), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// [test/prog_data_model.sv]
// program memory and banked data file behind the decoder
`timescale 1ns/100ps
`default_nettype none
module prog_data_model
   import bit_branch_pkg::*;
(
   // clock
   input wire logic clk,
   // program memory
   input wire logic [PC_W-1:0] prog_addr,
   output logic [INSN_W-1:0] prog_rdata,
   // data file
   input wire logic [DADDR_W-1:0] data_addr,
   input wire logic data_rd_en,
   output logic [7:0] data_rdata,
   input wire logic data_wr_en,
   input wire logic [7:0] data_wdata
);
   logic [INSN_W-1:0] rom [0:127];
   logic [7:0] dmem [0:4095];
   assign prog_rdata = rom[prog_addr[7:1]];
   // outside a read the lines carry the inverted byte at data_addr
   assign data_rdata = data_rd_en ? dmem[data_addr] : ~dmem[data_addr];
   always @(posedge clk)
   begin
      if (data_wr_en)
         dmem[data_addr] <= data_wdata;
   end
endmodule : prog_data_model
`default_nettype wire

// [test/tb_bit_branch_decode.sv]
// self-checking bench for the bit, branch, call and clear decoder
`timescale 1ns/100ps
`default_nettype none
module tb_bit_branch_decode
   import bit_branch_pkg::*;
;
   logic clk, rst_b, data_rd_en, data_wr_en, stack_push, watchdog_clear;
   logic [PC_W-1:0] prog_addr, stack_top;
   logic [INSN_W-1:0] prog_rdata;
   logic [DADDR_W-1:0] data_addr;
   logic [7:0] data_rdata, data_wdata;
   logic timeout_event, sleep_event, s_axi_awvalid, s_axi_awready;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int mismatches, n_tests, cycles, pushes, wdogs;
   bit_branch_decode uut (.clk(clk), .rst_b(rst_b), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata), .data_addr(data_addr),
      .data_rd_en(data_rd_en), .data_rdata(data_rdata),
      .data_wr_en(data_wr_en), .data_wdata(data_wdata),
      .stack_push(stack_push), .stack_top(stack_top),
      .watchdog_clear(watchdog_clear), .timeout_event(timeout_event),
      .sleep_event(sleep_event), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   prog_data_model pm (.clk(clk), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata), .data_addr(data_addr),
      .data_rd_en(data_rd_en), .data_rdata(data_rdata),
      .data_wr_en(data_wr_en), .data_wdata(data_wdata));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // run is a few hundred clocks; this ceiling only catches hangs
   always @(posedge clk)
   begin
      cycles++;
      if (stack_push === 1'b1) pushes++;
      if (watchdog_clear === 1'b1) wdogs++;
      if (cycles == 20000)
      begin
         mismatches++;
         summarize();
      end
   end
   // ==========================================================
   // shared tasks
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         n_tests++;
         if (got !== exp)
         begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         end
      end
   endtask : chk
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      begin
         @(posedge clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask : axw
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      begin
         @(posedge clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask : axr
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask : summarize
   // ==========================================================
   // scenarios
   task t_regs;
      logic [31:0] d;
      logic [1:0] r;
      begin
         axr(OFS_STATUS, d, r);
         chk("status reset", 32'h0000_000C, d);
         axr(8'h24, d, r);
         chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
         axw(OFS_WSHAD, 32'h0000_00FF, r);
         chk("read-only resp", 32'(RESP_SLVERR), 32'(r));
         @(posedge clk);
         timeout_event <= 1'b1;
         sleep_event <= 1'b1;
         @(posedge clk);
         timeout_event <= 1'b0;
         sleep_event <= 1'b0;
         axr(OFS_STATUS, d, r);
         chk("status after events", 32'h0000_0000, d);
         $display("register test done");
      end
   endtask : t_regs
   task t_program;
      logic [1:0] r;
      begin
         axw(OFS_WORK, 32'h0000_005A, r);
         axw(OFS_BANK, 32'h0000_0002, r);
         axw(OFS_PC, 32'h0000_0000, r);
         axw(OFS_CTRL, 32'h0000_0001, r);
         while (pm.dmem[12'h033] !== 8'h00) @(posedge clk);
         axw(OFS_CTRL, 32'h0000_0000, r);
         chk("inverted bit", 32'h0000_007D, 32'(pm.dmem[12'h010]));
         chk("bank 2 twin", 32'h0000_00EE, 32'(pm.dmem[12'h210]));
         chk("cleared reg", 32'h0000_0000, 32'(pm.dmem[12'h220]));
         chk("access twin", 32'h0000_00EE, 32'(pm.dmem[12'h020]));
         chk("skipped word", 32'h0000_00A5, 32'(pm.dmem[12'h030]));
         chk("branched over", 32'h0000_00A5, 32'(pm.dmem[12'h031]));
         chk("fall through", 32'h0000_0000, 32'(pm.dmem[12'h032]));
         chk("access high", 32'h0000_0000, 32'(pm.dmem[12'hF90]));
         chk("low half kept", 32'h0000_00EE, 32'(pm.dmem[12'h090]));
         $display("program test done");
      end
   endtask : t_program
   task t_call;
      logic [31:0] d;
      logic [1:0] r;
      begin
         chk("return addr", 32'h0000_0014, 32'(stack_top));
         chk("push count", 32'h0000_0001, 32'(pushes));
         chk("wdog pulses", 32'h0000_0001, 32'(wdogs));
         axr(OFS_STATUS, d, r);
         chk("status end", 32'h0000_000D, d);
         axr(OFS_WSHAD, d, r);
         chk("work shadow", 32'h0000_005A, d);
         axr(OFS_SSHAD, d, r);
         chk("status shadow", 32'h0000_0001, d);
         axr(OFS_BSHAD, d, r);
         chk("bank shadow", 32'h0000_0002, d);
         $display("call test done");
      end
   endtask : t_call
   task t_ovf;
      logic [1:0] r;
      begin
         axw(OFS_STATUS, 32'h0000_0002, r);
         axw(OFS_PC, 32'h0000_0060, r);
         axw(OFS_CTRL, 32'h0000_0001, r);
         while (pm.dmem[12'h035] !== 8'h00) @(posedge clk);
         axw(OFS_CTRL, 32'h0000_0000, r);
         chk("ovf taken", 32'h0000_00EE, 32'(pm.dmem[12'h034]));
         $display("overflow test done");
      end
   endtask : t_ovf
   initial
   begin
      rst_b = 1'b0;
      {timeout_event, sleep_event, s_axi_awvalid, s_axi_wvalid} = 4'h0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      for (int i = 0; i < 4096; i++) pm.dmem[i] = 8'hEE;
      for (int i = 0; i < 128; i++) pm.rom[i] = OPC_NOP;
      {pm.dmem[12'h010], pm.dmem[12'h220]} = 16'h755A;
      {pm.dmem[12'h030], pm.dmem[12'h031]} = 16'hA5A5;
      {pm.dmem[12'h032], pm.dmem[12'h033]} = 16'hA5A5;
      // invert, clear banked, test-skip, branch z, branch ov, call s=1
      {pm.rom[0], pm.rom[1], pm.rom[2], pm.rom[3]} = 64'h7610_6B20_A610_6A30;
      {pm.rom[4], pm.rom[5], pm.rom[6], pm.rom[7]} = 64'hE001_6A31_E47F_6A32;
      {pm.rom[8], pm.rom[9], pm.rom[32], pm.rom[33]} = 64'hED20_F000_0004_6A90;
      // high access half, end marker; taken overflow branch at 0x60
      pm.rom[34] = 16'h6A33;
      {pm.rom[48], pm.rom[49], pm.rom[50]} = 48'hE401_6A34_6A35;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_program();
      t_call();
      t_ovf();
      summarize();
   end
endmodule : tb_bit_branch_decode
`default_nettype wire
